// ### hw/efp_event_flags.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Bits 12-15 latchups, bits 16-23 command echo
// - Latch each source until read and clear
// - Read and clear empties latch and interrupt
// - Timer and saturation always recorded, mask blocks propagation
// - Masked front-end faults neither recorded nor propagated
// - Measurement faults cleared at measurement start
// - Latchup stops only its own telescope
// - Propagation status bits never raise interrupt
// - Edge detection, one BREAK per cause
// - Pair power opcode, bits 6-7, echo byte
// - Read and clear code, no arguments
// - Bits 2-4 timer and saturation flags
// - Bit 5 always reads zero
module efp_event_flags
    import efp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Decoded command bytes from the serial receiver
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_byte_i,
    // Internal event sources, same clock
    input wire logic timer_alarm_i,
    input wire logic [1:0] sat_i,
    input wire logic [1:0] prop_en_i,
    input wire logic [1:0] meas_active_i,
    input wire logic [1:0] meas_start_i,
    input wire logic [15:0] event_mask_i,
    // Front-end chip pins, asynchronous
    input wire logic [3:0] cfg_err_pin_i,
    input wire logic [1:0] latchup_ana_pin_i,
    input wire logic [1:0] latchup_dig_pin_i,
    // Response and link signalling
    output efp_resp_t resp_o,
    output logic break_req_o,
    output logic irq_o,
    // Telescope and power control
    output logic [1:0] meas_stop_o,
    output logic [1:0] pair_power_o
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [7:0] fe_pins;
    logic [7:0] fe_rise;

    assign fe_pins = {latchup_dig_pin_i, latchup_ana_pin_i, cfg_err_pin_i};

    efp_pin_sync #(
        .W(8)
    ) u_fe_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(fe_pins),
        .level_o(),
        .rise_o(fe_rise)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0] flags_reg;       // Latched causes
    logic [15:0] flags_next;
    logic [2:0] evt_prev_reg;     // Timer and saturation history
    logic [2:0] evt_prev_next;
    logic irq_reg;
    logic irq_next;
    logic brk_reg;
    logic brk_next;
    logic [1:0] stop_reg;
    logic [1:0] stop_next;
    logic [1:0] pwr_reg;
    logic [1:0] pwr_next;
    efp_resp_t resp_reg;
    efp_resp_t resp_next;

    // Working terms
    logic [15:0] edge_vec;        // Rising edges per cause
    logic [15:0] gate_mask;       // Mask plus powered-down pairs
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] fire_vec;        // Causes allowed to propagate
    logic [15:0] report;
    logic [2:0] evt_now;
    logic read_clear;
    logic pwr_cmd;
    logic fe01_edge;
    logic fe23_edge;
    logic [15:0] fe_live;         // Front-end edges that survive masking

    // True when any front-end cause of one pair is present
    function automatic logic pair_hit(input logic [15:0] v, input logic [15:0] pair);
        return |(v & pair);
    endfunction

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        evt_now = {sat_i, timer_alarm_i};
        evt_prev_next = evt_now;
        read_clear = cmd_valid_i && (cmd_byte_i == EFP_READ_CLEAR_CODE);
        pwr_cmd = cmd_valid_i && (cmd_byte_i[5:0] == EFP_PAIR_POWER_OP);

        // A powered-down pair has its fault inputs masked
        gate_mask = event_mask_i;
        if (!pwr_reg[0]) begin
            gate_mask = gate_mask | EFP_PAIR01;
        end
        if (!pwr_reg[1]) begin
            gate_mask = gate_mask | EFP_PAIR23;
        end

        // Edge-sensitive detection of every cause
        edge_vec = '0;
        edge_vec[EFP_BIT_TIMER] = evt_now[0] & ~evt_prev_reg[0];
        edge_vec[EFP_BIT_SAT01] = evt_now[1] & ~evt_prev_reg[1];
        edge_vec[EFP_BIT_SAT23] = evt_now[2] & ~evt_prev_reg[2];
        edge_vec[EFP_BIT_CFG0 +: 4] = fe_rise[3:0];
        edge_vec[EFP_BIT_LU_A01] = fe_rise[4];
        edge_vec[EFP_BIT_LU_D01] = fe_rise[6];
        edge_vec[EFP_BIT_LU_A23] = fe_rise[5];
        edge_vec[EFP_BIT_LU_D23] = fe_rise[7];

        // Summary bits see only faults that survive the mask, so a masked
        // latchup cannot slip into the latch through bit 6 or 7
        fe_live = edge_vec & ~gate_mask;
        fe01_edge = pair_hit(fe_live, EFP_PAIR01);
        fe23_edge = pair_hit(fe_live, EFP_PAIR23);
        edge_vec[EFP_BIT_MEAS01] = fe01_edge & meas_active_i[0];
        edge_vec[EFP_BIT_MEAS23] = fe23_edge & meas_active_i[1];

        // Front-end faults are dropped entirely when masked
        // Timer and saturation always land; their mask only stops propagation
        set_vec = edge_vec & EFP_STORED & ~(gate_mask & EFP_REC_GATED);
        fire_vec = set_vec & EFP_PROPAGATE & ~gate_mask;

        // Clears: whole latch on read, measurement bits on start
        clr_vec = '0;
        if (read_clear) begin
            clr_vec = 16'hffff;
        end
        if (meas_start_i[0]) begin
            clr_vec[EFP_BIT_MEAS01] = 1'b1;
        end
        if (meas_start_i[1]) begin
            clr_vec[EFP_BIT_MEAS23] = 1'b1;
        end
        // Set wins over clear so no event is lost
        flags_next = (flags_reg & ~clr_vec) | set_vec;

        // Interrupt line is sticky until read and clear
        // A cause landing in the clearing cycle raises it again at once
        if (read_clear) begin
            irq_next = |fire_vec;
        end else begin
            irq_next = irq_reg | (|fire_vec);
        end

        // One BREAK per cause: only a cause not yet latched fires
        // A read and clear re-arms every cause
        if (read_clear) begin
            brk_next = |fire_vec;
        end else begin
            brk_next = |(fire_vec & ~flags_reg);
        end

        // Latchup stops only the telescope owning that pair
        stop_next[0] = set_vec[EFP_BIT_LU_A01] | set_vec[EFP_BIT_LU_D01];
        stop_next[1] = set_vec[EFP_BIT_LU_A23] | set_vec[EFP_BIT_LU_D23];

        // Response assembly; reserved bit stays zero
        report = flags_reg & EFP_STORED;
        report[EFP_BIT_PROP01] = prop_en_i[0];
        report[EFP_BIT_PROP23] = prop_en_i[1];
        report[EFP_BIT_ZERO] = 1'b0;
        pwr_next = pwr_reg;
        resp_next = '0;
        if (read_clear) begin
            resp_next.valid = 1'b1;
            resp_next.wide = 1'b1;
            resp_next.word = {cmd_byte_i, report};
        end else if (pwr_cmd) begin
            pwr_next = cmd_byte_i[EFP_PWR_LSB +: 2];
            resp_next.valid = 1'b1;
            resp_next.word = {16'h0000, cmd_byte_i};
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_reg <= EFP_FLAG_RESET;
            evt_prev_reg <= 3'h0;
            irq_reg <= 1'b0;
            brk_reg <= 1'b0;
            stop_reg <= 2'h0;
            pwr_reg <= EFP_PWR_RESET;
            resp_reg <= '0;
        end else begin
            flags_reg <= flags_next;
            evt_prev_reg <= evt_prev_next;
            irq_reg <= irq_next;
            brk_reg <= brk_next;
            stop_reg <= stop_next;
            pwr_reg <= pwr_next;
            resp_reg <= resp_next;
        end
    end

    // Every output comes straight from a register
    assign resp_o = resp_reg;
    assign break_req_o = brk_reg;
    assign irq_o = irq_reg;
    assign meas_stop_o = stop_reg;
    assign pair_power_o = pwr_reg;

endmodule

// ### hw/efp_pkg.sv
package efp_pkg;

    // ----------------------------------------------------------------
    // Command codes (byte bit i is command bit i, bit 0 sent first)
    // ----------------------------------------------------------------
    localparam logic [7:0] EFP_READ_CLEAR_CODE = 8'h0e;
    localparam logic [5:0] EFP_PAIR_POWER_OP = 6'h01;
    localparam int EFP_PWR_LSB = 6;
    localparam logic [1:0] EFP_PWR_RESET = 2'h0;

    // ----------------------------------------------------------------
    // Event flag latch layout
    // ----------------------------------------------------------------
    localparam int EFP_FLAG_W = 16;
    localparam int EFP_BIT_PROP01 = 0;
    localparam int EFP_BIT_PROP23 = 1;
    localparam int EFP_BIT_TIMER = 2;
    localparam int EFP_BIT_SAT01 = 3;
    localparam int EFP_BIT_SAT23 = 4;
    localparam int EFP_BIT_ZERO = 5;
    localparam int EFP_BIT_MEAS01 = 6;
    localparam int EFP_BIT_MEAS23 = 7;
    localparam int EFP_BIT_CFG0 = 8;
    localparam int EFP_BIT_LU_A01 = 12;
    localparam int EFP_BIT_LU_D01 = 13;
    localparam int EFP_BIT_LU_A23 = 14;
    localparam int EFP_BIT_LU_D23 = 15;
    localparam int EFP_ECHO_LSB = 16;
    localparam logic [15:0] EFP_FLAG_RESET = 16'h0000;
    // Bits that are stored at all (status bits 0, 1 and bit 5 are not)
    localparam logic [15:0] EFP_STORED = 16'hffdc;
    // Bits whose recording is suppressed by the mask
    localparam logic [15:0] EFP_REC_GATED = 16'hffc0;
    // Bits that may raise the interrupt line and a BREAK
    localparam logic [15:0] EFP_PROPAGATE = 16'hffdc;
    // Front-end bits that belong to pair 0/1 and to pair 2/3
    localparam logic [15:0] EFP_PAIR01 = 16'h3340;
    localparam logic [15:0] EFP_PAIR23 = 16'hcc80;

    // ----------------------------------------------------------------
    // Response carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;        // One-cycle strobe
        logic wide;         // 1: 24-bit word, 0: 8-bit echo only
        logic [23:0] word;  // Response bits, bit 0 first on the link
    } efp_resp_t;

endpackage

// ### hw/efp_pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser with agreement filter and rising-edge pulse
module efp_pin_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Asynchronous pins
    input wire logic [W-1:0] pin_i,
    // Filtered level and rise pulse
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (W < 1) begin : g_bad_width
        $error("efp_pin_sync needs at least one pin");
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [W-1:0] s1_reg;      // First stage, read only by s2
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;   // Accepted level
    logic [W-1:0] rise_reg;
    logic [W-1:0] level_next;
    logic [W-1:0] rise_next;

    // Accept a change only once stages two and three agree
    always_comb begin
        level_next = level_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                level_next[i] = s3_reg[i];
            end
        end
        rise_next = level_next & ~level_reg;
    end

    // Register stage
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            level_reg <= '0;
            rise_reg <= '0;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
            rise_reg <= rise_next;
        end
    end

    assign level_o = level_reg;
    assign rise_o = rise_reg;

endmodule

// ### testbench/efp_host_model.sv
`timescale 1ns/1ps
module efp_host_model
    import efp_pkg::*;
(
    // Clock and answer from the device
    input wire logic clk_i,
    input wire efp_resp_t resp_i,
    // Received command bytes towards the device
    output logic cmd_valid_o,
    output logic [7:0] cmd_byte_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_byte_o = 8'h00;
    end

    // ----------------------------------------
    // Command encoding
    // ----------------------------------------
    function automatic logic [7:0] power_cmd(input logic [1:0] p);
        return {p, EFP_PAIR_POWER_OP};
    endfunction

    // Whole byte for one cycle, answer taken a cycle later
    task automatic send(input logic [7:0] b, output efp_resp_t r);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_byte_o <= b;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_byte_o <= ~b; // Idle byte must not look like the last one
        #1 r = resp_i;
    endtask
endmodule

// ### testbench/efp_event_flags_chk.sv
`timescale 1ns/1ps
module efp_event_flags_chk
    import efp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Watched inputs
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_byte_i,
    input wire logic timer_alarm_i,
    input wire logic [1:0] prop_en_i,
    input wire logic [15:0] event_mask_i,
    // Watched outputs
    input wire efp_resp_t resp_o,
    input wire logic break_req_o,
    input wire logic irq_o,
    input wire logic [1:0] meas_stop_o,
    input wire logic [1:0] pair_power_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    // ----------------------------------------
    // Command steps
    // ----------------------------------------
    logic rc_hit;
    logic pwr_hit;
    assign rc_hit = cmd_valid_i && cmd_byte_i == EFP_READ_CLEAR_CODE;
    assign pwr_hit = cmd_valid_i && cmd_byte_i[5:0] == EFP_PAIR_POWER_OP;
    sequence s_rc;
        rc_hit;
    endsequence
    sequence s_pwr;
        pwr_hit;
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_rc_answer: assert property (s_rc |=> resp_o.valid && resp_o.wide &&
        resp_o.word[23:16] == EFP_READ_CLEAR_CODE && resp_o.word[1:0] == $past(prop_en_i))
        else $error("read and clear answer wrong");
    chk_bit_five: assert property (resp_o.valid |-> !resp_o.word[EFP_BIT_ZERO])
        else $error("bit five set");
    chk_power_echo: assert property (s_pwr |=> resp_o.valid && !resp_o.wide &&
        resp_o.word == {16'h0000, $past(cmd_byte_i)} && pair_power_o == $past(cmd_byte_i[7:6]))
        else $error("power echo wrong");
    chk_power_hold: assert property (!pwr_hit |=> $stable(pair_power_o))
        else $error("power changed alone");
    chk_irq_sticky: assert property (irq_o && !rc_hit |=> irq_o)
        else $error("interrupt dropped");
    chk_timer_irq: assert property ($rose(timer_alarm_i) && !event_mask_i[EFP_BIT_TIMER]
        |=> irq_o) else $error("timer did not interrupt");
    chk_break_irq: assert property (break_req_o |-> irq_o)
        else $error("break without interrupt");
    chk_stop_power: assert property ((meas_stop_o & ~$past(pair_power_o)) == 2'h0)
        else $error("stop on unpowered pair");
    chk_refused_byte: assert property (cmd_valid_i && !rc_hit && !pwr_hit
        |=> !resp_o.valid) else $error("answer to unknown byte");
endmodule

bind efp_event_flags efp_event_flags_chk efp_event_flags_chk_i (.clk_i, .arst_n_i,
    .cmd_valid_i, .cmd_byte_i, .timer_alarm_i, .prop_en_i, .event_mask_i, .resp_o,
    .break_req_o, .irq_o, .meas_stop_o, .pair_power_o);

// ### testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import efp_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic timer_alarm_i = 1'b0;
    logic [1:0] sat_i = 2'h0;
    logic [1:0] prop_en_i = 2'h0;
    logic [1:0] meas_active_i = 2'h0;
    logic [1:0] meas_start_i = 2'h0;
    logic [15:0] event_mask_i = 16'h0000;
    logic [3:0] cfg_err_pin_i = 4'h0;
    logic [1:0] latchup_ana_pin_i = 2'h0;
    logic [1:0] latchup_dig_pin_i = 2'h0;
    logic cmd_valid_i;
    logic [7:0] cmd_byte_i;
    efp_resp_t resp_o;
    efp_resp_t r;
    logic break_req_o;
    logic irq_o;
    logic [1:0] meas_stop_o;
    logic [1:0] pair_power_o;
    logic [1:0] st;
    logic [15:0] lfsr = 16'h82bc;
    int failures = 0;
    int n_checks = 0;

    initial forever #4 clk_i = ~clk_i;

    efp_event_flags efp_event_flags_i (.clk_i, .arst_n_i, .cmd_valid_i, .cmd_byte_i,
        .timer_alarm_i, .sat_i, .prop_en_i, .meas_active_i, .meas_start_i, .event_mask_i,
        .cfg_err_pin_i, .latchup_ana_pin_i, .latchup_dig_pin_i, .resp_o, .break_req_o,
        .irq_o, .meas_stop_o, .pair_power_o);
    efp_host_model efp_host_model_i (.clk_i, .resp_i(resp_o), .cmd_valid_o(cmd_valid_i),
        .cmd_byte_o(cmd_byte_i));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Answer word: stored bits plus live status, code echoed on top
    function automatic logic [25:0] rc_word(input logic [15:0] f);
        return {2'b11, EFP_READ_CLEAR_CODE, (f & 16'hffdc) | {14'h0000, prop_en_i}};
    endfunction
    task automatic chk_w(input logic [25:0] got, input logic [25:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_b(input logic [1:0] got, input logic [1:0] exp);
        chk_w({24'h000000, got}, {24'h000000, exp});
    endtask
    task automatic rc(input logic [15:0] f);
        efp_host_model_i.send(EFP_READ_CLEAR_CODE, r);
        chk_w({r.valid, r.wide, r.word}, rc_word(f));
        chk_b({1'b0, irq_o}, 2'h0);
    endtask
    // Raise {sat, timer} for one level change, then look at {break, irq}
    task automatic rise(input logic [2:0] c, input logic [1:0] exp);
        @(posedge clk_i);
        {sat_i, timer_alarm_i} <= c;
        @(posedge clk_i);
        #1 chk_b({break_req_o, irq_o}, exp);
        @(posedge clk_i);
        {sat_i, timer_alarm_i} <= 3'h0;
    endtask
    // Pin causes pass a synchroniser, so watch a fixed 12-cycle window for the break
    task automatic wait_break();
        st = 2'h0;
        repeat (12) begin
            @(posedge clk_i);
            #1 if (break_req_o === 1'b1) st = meas_stop_o;
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk_i);
        #1 chk_b(pair_power_o, 2'h0);
        chk_b({break_req_o, irq_o}, 2'h0);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            efp_host_model_i.send(efp_host_model_i.power_cmd(2'(p)), r);
            chk_w({r.valid, r.wide, r.word}, {2'b10, 16'h0000, 2'(p), EFP_PAIR_POWER_OP});
            chk_b(pair_power_o, 2'(p));
        end
        efp_host_model_i.send(8'hff, r);
        chk_b({1'b0, r.valid}, 2'h0);
        @(posedge clk_i);
        prop_en_i <= lfsr[1:0];
        rise(3'h1, 2'h3);
        rise(3'h1, 2'h1);
        rc(16'h0004);
        rc(16'h0000);
        @(posedge clk_i);
        event_mask_i <= 16'h001c;
        rise(3'h1, 2'h0);
        rc(16'h0004);
        repeat (8) begin
            lfsr = step(lfsr);
            @(posedge clk_i);
            event_mask_i <= {11'h000, lfsr[4:3], 3'h0};
            prop_en_i <= lfsr[6:5];
            rise({lfsr[1:0], 1'b0}, {2{|(lfsr[1:0] & ~lfsr[4:3])}});
            rc({11'h000, lfsr[1:0], 3'h0});
        end
        @(posedge clk_i);
        event_mask_i <= 16'h0000;
        latchup_dig_pin_i <= 2'h1;
        wait_break();
        chk_b(st, 2'h1);
        rc(16'h2000);
        @(posedge clk_i);
        meas_active_i <= 2'h2;
        latchup_ana_pin_i <= 2'h2;
        wait_break();
        chk_b(st, 2'h2);
        @(posedge clk_i);
        meas_start_i <= 2'h2;
        @(posedge clk_i);
        meas_start_i <= 2'h0;
        rc(16'h4000);
        @(posedge clk_i);
        event_mask_i <= 16'h8000;
        latchup_dig_pin_i <= 2'h3;
        wait_break();
        chk_b({st[1], irq_o}, 2'h0);
        rc(16'h0000);
        // Pair 0/1 powered down: its faults vanish, pair 2/3 still reports
        efp_host_model_i.send(efp_host_model_i.power_cmd(2'h2), r);
        chk_b(pair_power_o, 2'h2);
        @(posedge clk_i);
        event_mask_i <= 16'h0000;
        cfg_err_pin_i <= 4'h5;
        wait_break();
        chk_b(st, 2'h0);
        rc(16'h0480);
        // Reset in mid-run with a cause latched and a pair powered
        rise(3'h1, 2'h3);
        @(posedge clk_i);
        arst_n_i <= 1'b0;
        @(posedge clk_i);
        #1 chk_b({break_req_o, irq_o}, 2'h0);
        chk_b(pair_power_o, 2'h0);
        @(posedge clk_i);
        arst_n_i <= 1'b1;
        rc(16'h0000);
        final_report();
    end

    // Whole run is well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        final_report();
    end
endmodule
